//--- wdt_top.sv
// Software watchdog and periodic interrupt timer.
// Assumes clk is the crystal input clock; host writes arrive on the same clock.
// What this block does
// [R1] Enabled watchdog drives external reset when its count expires unserviced.
// [R2] Software services by writing 55 then AA, in order, before time-out.
// [R3] Watchdog prescale bit selects undivided or divide-by-512 count clock.
// [R4] Watchdog prescale resets to one when clock-mode pin low, else zero.
// [R5] Time-out ratio is 2^9..2^15, or 2^18..2^24 when prescaled.
// [R6] New watchdog timing applies only after a complete service sequence.
// [R7] Periodic tick is crystal clock, optionally divided by 512, then by four.
// [R8] Periodic prescale resets to one when clock-mode pin low, else zero.
// [R9] Writing modulus starts the counter; modulus zero turns timer off.
// [R10] At zero the counter requests an interrupt, reloads and keeps counting.
// [R11] A new modulus loads only when the current count completes.
// [R12] Request level zero disables interrupt; levels one to seven are presented.
// [R13] Periodic request beats an external request of the same level.
// [R14] Counter keeps running and reloading while the level is zero.
// [R15] Vector is driven during a request and resets to 0f.
// [R16] Entering low-power stop latches the processor interrupt mask.
// [R17] Watchdog count freezes during stop, resumes after, is not reset.
// [R18] Periodic timer runs in stop; higher-level request ends the stop.
// [R19] Software writes zero modulus before stop to halt the periodic timer.
// [R20] Debug freeze with freeze-watchdog bit halts both timers.
// [R21] Only AA directly after 55 restarts the count; other values break it.
`timescale 1ns/10ps
`include "wdt_cfg.svh"
module wdt_top #(
   parameter int wd_base_log2 = `WD_BASE_LOG2,
   parameter int prescale_div = `PRESCALE_DIV
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic clock_mode_pin,
   input wire logic wr_en,
   input wire wdt_pkg::reg_sel_t wr_sel,
   input wire logic [15:0] wr_data,
   input wire logic debug_freeze,
   input wire logic freeze_watchdog_bit,
   input wire logic low_power_stop,
   input wire logic [2:0] cpu_int_mask,
   input wire logic [2:0] ext_irq_level,
   input wire logic iack,
   input wire logic [2:0] iack_level,
   output logic ext_reset_ff,
   output logic [2:0] periodic_irq_level_ff,
   output logic vector_drive_ff,
   output logic [7:0] vector_out_ff,
   output logic periodic_first_ff,
   output logic stop_wake_ff,
   output logic [7:0] protection_ctrl_ff,
   output logic [8:0] periodic_timer_ff
);
   localparam int CW = wd_base_log2 + 6;

   // ------------------------------------------------------------
   // Elaboration check
   // ------------------------------------------------------------
   if (wd_base_log2 < 1 || wd_base_log2 > 24) begin : g_bad_base
      $error("wd_base_log2 out of range");
   end

   // Last count value before expiry for a timing code
   function automatic logic [CW-1:0] wd_last(input logic [1:0] timing);
      wd_last = CW'((64'd1 << (wd_base_log2 + 2 * int'(timing))) - 64'd1);   // [R5]
   endfunction : wd_last

   // ------------------------------------------------------------
   // Reset release and pin synchronisers
   // ------------------------------------------------------------
   logic rst_meta_ff, rst_n;
   logic mode_meta_ff, mode_sync_ff;
   logic [1:0] strap_cnt_ff;
   logic strap_done_ff;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta_ff <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n <= rst_meta_ff;
      end
   end

   // Clock-mode pin comes from outside, two flops before use
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_meta_ff <= 1'b0;
         mode_sync_ff <= 1'b0;
      end else begin
         mode_meta_ff <= clock_mode_pin;
         mode_sync_ff <= mode_meta_ff;
      end
   end

   // Strap is caught once, after the synchroniser has filled
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         strap_cnt_ff <= 2'h0;
         strap_done_ff <= 1'b0;
      end else if (!strap_done_ff) begin
         strap_cnt_ff <= strap_cnt_ff + 2'h1;
         strap_done_ff <= (strap_cnt_ff == `STRAP_WAIT);
      end
   end
   wire strap_take = !strap_done_ff && (strap_cnt_ff == `STRAP_WAIT);

   // ------------------------------------------------------------
   // Host write decode
   // ------------------------------------------------------------
   wire wr_svc = wr_en && (wr_sel == wdt_pkg::SEL_SERVICE);
   wire wr_spc = wr_en && (wr_sel == wdt_pkg::SEL_PROTECTION);
   wire wr_ptr = wr_en && (wr_sel == wdt_pkg::SEL_PERIODIC_TIMER);
   wire wr_pic = wr_en && (wr_sel == wdt_pkg::SEL_PERIODIC_CTRL);

   logic wd_enable_ff, wd_prescale_ff, pit_prescale_ff;
   logic [1:0] wd_timing_ff, wd_timing_act_ff;
   logic [7:0] modulus_ff, vector_ff;
   logic [2:0] level_ff;

   // Protection control; prescale strap overrides the reset value once
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wd_enable_ff <= `SPC_ENABLE_RST;
         wd_prescale_ff <= 1'b1;
         wd_timing_ff <= `SPC_TIMING_RST;
      end else if (wr_spc) begin
         wd_enable_ff <= wr_data[`SPC_ENABLE_POS];
         wd_prescale_ff <= wr_data[`SPC_PRESCALE_POS];
         wd_timing_ff <= wr_data[`SPC_TIMING_LSB +: 2];
      end else if (strap_take) begin
         wd_prescale_ff <= ~mode_sync_ff;   // [R4]
      end
   end

   // Periodic timer register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pit_prescale_ff <= 1'b1;
         modulus_ff <= 8'h00;
      end else if (wr_ptr) begin
         pit_prescale_ff <= wr_data[`PTR_PRESCALE_POS];
         modulus_ff <= wr_data[`PTR_MODULUS_LSB +: 8];
      end else if (strap_take) begin
         pit_prescale_ff <= ~mode_sync_ff;   // [R8]
      end
   end

   // Periodic interrupt control
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         level_ff <= `PIC_LEVEL_RST;
         vector_ff <= `PIC_VECTOR_RST;   // [R15]
      end else if (wr_pic) begin
         level_ff <= wr_data[`PIC_LEVEL_LSB +: 3];
         vector_ff <= wr_data[`PIC_VECTOR_LSB +: 8];
      end
   end

   // ------------------------------------------------------------
   // Tick generation
   // ------------------------------------------------------------
   tick_if tk ();
   logic stop_ff;
   assign tk.wd_prescale = wd_prescale_ff;
   assign tk.pit_prescale = pit_prescale_ff;
   assign tk.halt = debug_freeze & freeze_watchdog_bit;   // [R20]
   assign tk.wd_stop = stop_ff;

   clock_prescaler #(.prescale_div(prescale_div)) u_prescaler (
      .clk(clk),
      .rst_n(rst_n),
      .tk(tk.prescaler)
   );

   // ------------------------------------------------------------
   // Watchdog service sequence and counter
   // ------------------------------------------------------------
   logic armed_ff;
   logic [CW-1:0] wd_count_ff;
   wire svc_done = wr_svc && armed_ff && (wr_data[7:0] == `SVC_KEY_SECOND);   // [R21]

   // First key arms; the second key only counts straight after it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) armed_ff <= 1'b0;
      else if (wr_svc) armed_ff <= (wr_data[7:0] == `SVC_KEY_FIRST);   // [R2] [R21]
   end

   // Timing change waits for a full service so a stray write cannot shorten it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) wd_timing_act_ff <= `SPC_TIMING_RST;
      else if (svc_done) wd_timing_act_ff <= wd_timing_ff;   // [R6]
   end

   // Counter is gated by the tick, which is held off in stop and freeze
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) wd_count_ff <= '0;
      else if (svc_done) wd_count_ff <= '0;   // [R21]
      else if (tk.wd_tick && wd_enable_ff && !ext_reset_ff) wd_count_ff <= wd_count_ff + 1'b1; // [R17]
   end

   // Expiry holds reset asserted until the device itself is reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) ext_reset_ff <= 1'b0;
      else if (tk.wd_tick && wd_enable_ff && !svc_done &&
               wd_count_ff == wd_last(wd_timing_act_ff)) ext_reset_ff <= 1'b1;   // [R1]
   end

   // ------------------------------------------------------------
   // Periodic modulus counter and request
   // ------------------------------------------------------------
   logic [7:0] pit_count_ff;
   logic pend_ff;
   wire pit_wrap = tk.pit_tick && (modulus_ff != 8'h00) && (pit_count_ff <= 8'h01);

   // Runs regardless of level; a running count is disturbed only by a write of modulus zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) pit_count_ff <= 8'h00;
      else if (modulus_ff == 8'h00) pit_count_ff <= 8'h00;   // [R9] [R19]
      else if (pit_wrap) pit_count_ff <= modulus_ff;   // [R10] [R11] [R14]
      else if (tk.pit_tick) pit_count_ff <= pit_count_ff - 8'h01;
   end

   // Pending request; a new wrap wins over a simultaneous acknowledge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) pend_ff <= 1'b0;
      else if (level_ff == 3'h0) pend_ff <= 1'b0;   // [R12]
      else if (pit_wrap) pend_ff <= 1'b1;   // [R10]
      else if (iack && iack_level == level_ff) pend_ff <= 1'b0;
   end

   // Request outputs toward the processor and the arbiter
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         periodic_irq_level_ff <= 3'h0;
         vector_drive_ff <= 1'b0;
         vector_out_ff <= 8'h00;
         periodic_first_ff <= 1'b0;
      end else begin
         periodic_irq_level_ff <= pend_ff ? level_ff : 3'h0;   // [R12]
         vector_drive_ff <= pend_ff;   // [R15]
         vector_out_ff <= pend_ff ? vector_ff : 8'h00;   // [R15]
         periodic_first_ff <= pend_ff && (level_ff >= ext_irq_level);   // [R13]
      end
   end

   // ------------------------------------------------------------
   // Low-power stop
   // ------------------------------------------------------------
   logic [2:0] mask_ff;

   // Mask is latched on entry only; later mask changes do not move it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stop_ff <= 1'b0;
         mask_ff <= 3'h7;
      end else begin
         stop_ff <= low_power_stop;
         if (low_power_stop && !stop_ff) mask_ff <= cpu_int_mask;   // [R16]
      end
   end

   // Wake only for a level strictly above the latched mask
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) stop_wake_ff <= 1'b0;
      else stop_wake_ff <= stop_ff && pend_ff && (level_ff > mask_ff);   // [R18]
   end

   // Read-back of the software-visible settings
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         protection_ctrl_ff <= 8'h00;
         periodic_timer_ff <= 9'h000;
      end else begin
         protection_ctrl_ff <= {wd_enable_ff, wd_prescale_ff, wd_timing_ff, 4'h0};
         periodic_timer_ff <= {pit_prescale_ff, modulus_ff};
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   wd_expire_a: assert property (   // [R1]
      tk.wd_tick && wd_enable_ff && !svc_done && wd_count_ff == wd_last(wd_timing_act_ff)
      |=> ext_reset_ff)
      else $error("watchdog expiry did not assert reset");

   svc_restart_a: assert property (   // [R21]
      svc_done |=> wd_count_ff == '0 && !armed_ff)
      else $error("service sequence did not restart watchdog");

   svc_order_a: assert property (   // [R2]
      wr_svc && !armed_ff && !tk.wd_tick |=> wd_count_ff == $past(wd_count_ff))
      else $error("lone second key restarted watchdog");

   timing_hold_a: assert property (   // [R6]
      !svc_done |=> wd_timing_act_ff == $past(wd_timing_act_ff))
      else $error("timing changed without service");

   // Tick enable is registered, so the count may still step once on entry
   stop_freeze_a: assert property (   // [R17]
      (stop_ff && !wr_svc) [*2] |=> wd_count_ff == $past(wd_count_ff))
      else $error("watchdog counted during stop");

   freeze_halt_a: assert property (   // [R20]
      (tk.halt && !wr_svc) [*2] |=> wd_count_ff == $past(wd_count_ff))
      else $error("watchdog counted during debug freeze");

   pit_reload_a: assert property (   // [R10]
      pit_wrap && level_ff != 3'h0 && !wr_ptr && !wr_pic
      |=> pit_count_ff == $past(modulus_ff) && pend_ff ##1 vector_drive_ff)
      else $error("periodic wrap missed reload or request");

   // A modulus write lands one cycle later, so its own cycle is left out
   pit_off_a: assert property (   // [R9]
      modulus_ff == 8'h00 && !wr_ptr |=> pit_count_ff == 8'h00 && !pit_wrap)
      else $error("periodic timer ran with zero modulus");

   vector_drive_a: assert property (   // [R15]
      pend_ff |=> vector_drive_ff && vector_out_ff == $past(vector_ff))
      else $error("vector not driven during request");

   same_level_first_a: assert property (   // [R13]
      pend_ff && level_ff == ext_irq_level |=> periodic_first_ff)
      else $error("periodic request lost to same-level external");

   level_zero_a: assert property (   // [R12]
      level_ff == 3'h0 && !wr_pic [*2] |-> ##1 periodic_irq_level_ff == 3'h0)
      else $error("request presented at level zero");

   wake_a: assert property (   // [R18]
      stop_ff && pend_ff && level_ff > mask_ff |=> stop_wake_ff)
      else $error("periodic request failed to wake");

   mask_hold_a: assert property (   // [R16]
      stop_ff && low_power_stop |=> mask_ff == $past(mask_ff))
      else $error("latched mask moved during stop");
endmodule : wdt_top

//--- wdt_cfg.svh
// Constants for the watchdog and periodic interrupt timer: field positions,
// reset values, service keys and timing counts.
// Assumes inclusion by bare name from the two design files.
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

// ------------------------------------------------------------
// Service keys
// ------------------------------------------------------------
`define SVC_KEY_FIRST 8'h55
`define SVC_KEY_SECOND 8'haa

// ------------------------------------------------------------
// System protection control fields
// ------------------------------------------------------------
`define SPC_ENABLE_POS 7
`define SPC_PRESCALE_POS 6
`define SPC_TIMING_LSB 4
`define SPC_ENABLE_RST 1'b1
`define SPC_TIMING_RST 2'h0

// ------------------------------------------------------------
// Periodic timer register and interrupt control fields
// ------------------------------------------------------------
`define PTR_PRESCALE_POS 8
`define PTR_MODULUS_LSB 0
`define PIC_LEVEL_LSB 8
`define PIC_VECTOR_LSB 0
`define PIC_LEVEL_RST 3'h0
`define PIC_VECTOR_RST 8'h0f

// ------------------------------------------------------------
// Timing counts
// ------------------------------------------------------------
`define PRESCALE_DIV 512
`define PIT_TICK_DIV 4
`define WD_BASE_LOG2 9
`define STRAP_WAIT 2'h2

`endif

//--- wdt_pkg.sv
// Types shared by the watchdog and periodic timer modules.
// Assumes nothing beyond the constants header.
package wdt_pkg;
   // Which software-visible register a host write targets
   typedef enum logic [1:0] {
      SEL_SERVICE,
      SEL_PROTECTION,
      SEL_PERIODIC_TIMER,
      SEL_PERIODIC_CTRL
   } reg_sel_t;
endpackage : wdt_pkg

//--- tick_if.sv
// Tick enables and their controls between the top and the prescaler.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface tick_if;
   logic wd_prescale;
   logic pit_prescale;
   logic halt;
   logic wd_stop;
   logic wd_tick;
   logic pit_tick;
   modport prescaler (input wd_prescale, pit_prescale, halt, wd_stop,
                      output wd_tick, pit_tick);
   modport user (output wd_prescale, pit_prescale, halt, wd_stop,
                 input wd_tick, pit_tick);
endinterface : tick_if

//--- clock_prescaler.sv
// Shared divide-by-512 prescaler and the tick enables of both timers.
// Assumes a synchronous active-low reset copy from the top module.
`timescale 1ns/10ps
`include "wdt_cfg.svh"
module clock_prescaler #(
   parameter int prescale_div = `PRESCALE_DIV
) (
   input wire logic clk,
   input wire logic rst_n,
   tick_if.prescaler tk
);
   localparam int PW = $clog2(prescale_div);

   // ------------------------------------------------------------
   // Elaboration check
   // ------------------------------------------------------------
   if (prescale_div < 2 || (1 << PW) != prescale_div) begin : g_bad_div
      $error("prescale_div must be a power of two");
   end

   logic [PW-1:0] pre_cnt_ff;
   logic [1:0] quarter_ff;
   logic tick512;
   logic pit_src;

   // ------------------------------------------------------------
   // Free-running prescaler; never halted so both timers share phase
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) pre_cnt_ff <= '0;
      else pre_cnt_ff <= pre_cnt_ff + 1'b1;
   end

   // Source selection: undivided clock or one pulse per prescale period
   assign tick512 = (pre_cnt_ff == {PW{1'b1}});
   assign pit_src = (tk.pit_prescale ? tick512 : 1'b1) & ~tk.halt;   // [R7] [R20]

   // Divide by four ahead of the modulus counter
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) quarter_ff <= 2'h0;
      else if (pit_src) quarter_ff <= quarter_ff + 2'h1;   // [R7]
   end

   // Registered tick enables; the stop gate affects the watchdog only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tk.pit_tick <= 1'b0;
         tk.wd_tick <= 1'b0;
      end else begin
         tk.pit_tick <= pit_src & (quarter_ff == 2'h3);   // [R7] [R18]
         tk.wd_tick <= (tk.wd_prescale ? tick512 : 1'b1) & ~tk.halt & ~tk.wd_stop; // [R3] [R17]
      end
   end
endmodule : clock_prescaler

//--- host_model.sv
// Host processor model: register writes and interrupt acknowledge cycles.
// Assumes the block takes a write on each rising edge where wr_en is high.
`timescale 1ns/10ps
module host_model (
   input wire logic clk,
   input wire logic ack_on,
   input wire logic req,
   input wire logic [2:0] req_level,
   output wdt_pkg::reg_sel_t wr_sel,
   output logic wr_en,
   output logic [15:0] wr_data,
   output logic iack,
   output logic [2:0] iack_level
);
   // ----------------------------------------
   // Write cycles
   // ----------------------------------------
   // Idle bus at time zero
   initial begin
      wr_sel = wdt_pkg::SEL_SERVICE;
      wr_en = 1'b0;
      wr_data = 16'h0000;
   end

   // One write per call; strobe stays up so back-to-back writes need no gap
   task wr(input wdt_pkg::reg_sel_t sel, input logic [15:0] data);
      @(posedge clk);
      wr_en <= 1'b1;
      wr_sel <= sel;
      wr_data <= data;
   endtask : wr

   // Released data flips so a stale value never looks like a fresh write
   task idle;
      @(posedge clk);
      wr_en <= 1'b0;
      wr_data <= ~wr_data;
   endtask : idle

   // Both keys, in order, as consecutive service writes
   task service;
      wr(wdt_pkg::SEL_SERVICE, 16'h0055);
      wr(wdt_pkg::SEL_SERVICE, 16'h00aa);
      idle;
   endtask : service

   // Zero modulus ahead of stop when the periodic timer must halt
   task halt_periodic;
      wr(wdt_pkg::SEL_PERIODIC_TIMER, 16'h0000);
      idle;
   endtask : halt_periodic

   // ----------------------------------------
   // Interrupt acknowledge
   // ----------------------------------------
   // One-cycle pulse; the one-cycle gap is shorter than the clear, so each request is acknowledged twice
   always @(posedge clk) begin
      iack <= ack_on && req && !iack;
      iack_level <= req_level;
   end
endmodule : host_model

//--- tb_watchdog_and_periodic_timer.sv
// Self-checking bench for the watchdog and periodic interrupt timer.
// Assumes the host model makes the writes; the bench drives the other inputs.
`timescale 1ns/10ps
module tb_watchdog_and_periodic_timer;
   localparam int base = 3;
   localparam int pdiv = 8;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic mode_pin = 1'b1;
   logic dfrz = 1'b0;
   logic fsw = 1'b0;
   logic lps = 1'b0;
   logic [2:0] mask = 3'h7;
   logic [2:0] ext_lvl = 3'h0;
   logic ack_on = 1'b0;
   logic wr_en;
   logic iack;
   wdt_pkg::reg_sel_t wr_sel;
   logic [15:0] wr_data;
   logic [2:0] iack_level;
   logic ext_reset_ff;
   logic [2:0] level_ff;
   logic vdrive_ff;
   logic [7:0] vector_ff;
   logic first_ff;
   logic wake_ff;
   logic [7:0] prot_ff;
   logic [8:0] ptimer_ff;
   int n_errors = 0;
   int checks = 0;
   int cyc = 0;
   int last_rise = 0;

   // Clock and a cycle count for period checks
   always #12.5 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;

   // Short counts keep the run brief; expectations scale with them
   wdt_top #(.wd_base_log2(base), .prescale_div(pdiv)) dut (.clk(clk), .rstn(rstn),
      .clock_mode_pin(mode_pin), .wr_en(wr_en), .wr_sel(wr_sel), .wr_data(wr_data),
      .debug_freeze(dfrz), .freeze_watchdog_bit(fsw), .low_power_stop(lps),
      .cpu_int_mask(mask), .ext_irq_level(ext_lvl), .iack(iack), .iack_level(iack_level),
      .ext_reset_ff(ext_reset_ff), .periodic_irq_level_ff(level_ff),
      .vector_drive_ff(vdrive_ff), .vector_out_ff(vector_ff), .periodic_first_ff(first_ff),
      .stop_wake_ff(wake_ff), .protection_ctrl_ff(prot_ff), .periodic_timer_ff(ptimer_ff));

   host_model hm (.clk(clk), .ack_on(ack_on), .req(vdrive_ff), .req_level(level_ff),
      .wr_sel(wr_sel), .wr_en(wr_en), .wr_data(wr_data), .iack(iack),
      .iack_level(iack_level));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task tally_and_finish;
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : tally_and_finish

   // Reset held six cycles; strap is taken before the task returns
   task do_reset(input logic pin);
      @(posedge clk);
      rstn <= 1'b0;
      mode_pin <= pin;
      lps <= 1'b0;
      dfrz <= 1'b0;
      fsw <= 1'b0;
      ack_on <= 1'b0;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      repeat (6) @(posedge clk);
   endtask : do_reset

   // Edges until the external reset rises must fall in n +/- slack
   task automatic expire(input int n, input int slack);
      int k;
      k = 0;
      while (ext_reset_ff !== 1'b1 && k < n + slack + 8) begin
         @(posedge clk);
         #1;
         k++;
      end
      if (ext_reset_ff !== 1'b1) begin
         n_errors++;
         tally_and_finish;
      end
      check("reset_delay", 16'(k), (k >= n - slack && k <= n + slack) ? 16'(k) : 16'(n));
   endtask : expire

   // Next rising request; exp above zero checks the spacing from the last one
   task automatic rise(input int exp);
      int k;
      logic p;
      logic hit;
      k = 0;
      hit = 1'b0;
      p = vdrive_ff;
      while (!hit && k < 400) begin
         @(posedge clk);
         #1;
         k++;
         hit = (p === 1'b0 && vdrive_ff === 1'b1);
         p = vdrive_ff;
      end
      if (!hit) begin
         n_errors++;
         tally_and_finish;
      end
      if (exp > 0) check("period", 16'(cyc - last_rise), 16'(exp));
      last_rise = cyc;
   endtask : rise

   // No request may stand for n cycles, after a short settle
   task automatic quiet(input int n);
      int hi;
      hi = 0;
      repeat (3) @(posedge clk);
      repeat (n) begin
         @(posedge clk);
         #1;
         if (vdrive_ff !== 1'b0) hi++;
      end
      check("idle_request", 16'(hi), 16'h0000);
   endtask : quiet

   // Watchdog with stop or freeze held 20 cycles, a few ticks after service
   task halt_test(input logic s, input logic f, input logic b, input logic halts);
      do_reset(1'b1);
      hm.service;
      repeat (3) @(posedge clk);
      lps <= s;
      dfrz <= f;
      fsw <= b;
      repeat (20) @(posedge clk);
      lps <= 1'b0;
      dfrz <= 1'b0;
      fsw <= 1'b0;
      if (halts) expire(6, 2);
      else check("free_run", 16'(ext_reset_ff), 16'h0001);
   endtask : halt_test

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      // Strap levels: readback and expiry at both prescale settings
      do_reset(1'b1);
      hm.service;
      check("protection", 16'(prot_ff), 16'h0080);
      check("ptimer", 16'(ptimer_ff), 16'h0000);
      expire((1 << base) + 1, 1);
      do_reset(1'b0);
      hm.service;
      check("protection", 16'(prot_ff), 16'h00c0);
      check("ptimer", 16'(ptimer_ff), 16'h0100);
      expire((pdiv << base) + 1, pdiv + 1);
      // Every timing code, applied by the service that follows it
      for (int t = 0; t < 4; t++) begin
         do_reset(1'b1);
         hm.service;
         hm.wr(wdt_pkg::SEL_PROTECTION, 16'h0080 | 16'(t << 4));
         hm.service;
         expire((1 << (base + 2 * t)) + 1, 1);
      end
      // Timing change without service keeps the old period
      do_reset(1'b1);
      hm.service;
      hm.wr(wdt_pkg::SEL_PROTECTION, 16'h00b0);
      hm.idle;
      expire((1 << base) - 1, 1);
      // A wrong key between the two keys breaks the sequence
      do_reset(1'b1);
      hm.service;
      hm.wr(wdt_pkg::SEL_SERVICE, 16'h0055);
      hm.wr(wdt_pkg::SEL_SERVICE, 16'h0033);
      hm.wr(wdt_pkg::SEL_SERVICE, 16'h00aa);
      hm.idle;
      expire((1 << base) - 3, 1);
      // Another register written between the keys is harmless
      do_reset(1'b1);
      hm.service;
      hm.wr(wdt_pkg::SEL_SERVICE, 16'h0055);
      hm.wr(wdt_pkg::SEL_PERIODIC_CTRL, 16'h0000);
      hm.wr(wdt_pkg::SEL_SERVICE, 16'h00aa);
      hm.idle;
      expire((1 << base) + 1, 1);
      halt_test(1'b1, 1'b0, 1'b0, 1'b1);
      halt_test(1'b0, 1'b1, 1'b1, 1'b1);
      halt_test(1'b0, 1'b1, 1'b0, 1'b0);
      // Periodic timer with the watchdog off: levels one to seven, modulus 2
      do_reset(1'b1);
      hm.wr(wdt_pkg::SEL_PROTECTION, 16'h0000);
      ack_on <= 1'b1;
      ext_lvl <= 3'h4;
      hm.wr(wdt_pkg::SEL_PERIODIC_TIMER, 16'h0002);
      for (int lv = 1; lv < 8; lv++) begin
         hm.wr(wdt_pkg::SEL_PERIODIC_CTRL, {5'h00, 3'(lv), 8'h40 + 8'(lv)});
         hm.idle;
         rise(0);
         rise(8);
         check("level", 16'(level_ff), 16'(lv));
         check("vector", 16'(vector_ff), 16'h0040 + 16'(lv));
         check("first", 16'(first_ff), 16'(lv >= 4));
      end
      // New modulus waits for the running count to finish
      hm.wr(wdt_pkg::SEL_PERIODIC_TIMER, 16'h0005);
      hm.idle;
      rise(8);
      rise(20);
      hm.wr(wdt_pkg::SEL_PERIODIC_TIMER, 16'h0101);
      hm.idle;
      rise(0);
      rise(0);
      rise(4 * pdiv);
      // Level zero silences requests while the counter keeps going
      hm.wr(wdt_pkg::SEL_PERIODIC_CTRL, 16'h0055);
      hm.idle;
      quiet(80);
      hm.wr(wdt_pkg::SEL_PERIODIC_CTRL, 16'h0340);
      hm.idle;
      rise(0);
      rise(4 * pdiv);
      // Zero modulus before stop halts the timer
      hm.halt_periodic;
      lps <= 1'b1;
      repeat (80) @(posedge clk);
      quiet(100);
      lps <= 1'b0;
      // Wake from stop only above the mask latched at entry
      ack_on <= 1'b0;
      hm.wr(wdt_pkg::SEL_PERIODIC_TIMER, 16'h0002);
      hm.idle;
      mask <= 3'h2;
      lps <= 1'b1;
      rise(0);
      repeat (3) @(posedge clk);
      check("wake", 16'(wake_ff), 16'h0001);
      lps <= 1'b0;
      mask <= 3'h3;
      @(posedge clk);
      lps <= 1'b1;
      @(posedge clk);
      mask <= 3'h1;
      repeat (5) @(posedge clk);
      check("wake", 16'(wake_ff), 16'h0000);
      tally_and_finish;
   end
endmodule : tb_watchdog_and_periodic_timer
